// *** logic/dpsc_params.svh ***
`ifndef DPSC_PARAMS_SVH
`define DPSC_PARAMS_SVH
// register indices; byte address is four times the index
`define DPSC_IDX_ROUTE 10'h024
`define DPSC_IDX_DECIM 10'h025
`define DPSC_IDX_STAT 10'h028
// path_routing_control fields
`define DPSC_AVG_BIT 5
`define DPSC_SEL_HI 4
`define DPSC_SEL_LO 3
`define DPSC_FEAT_BIT 2
`define DPSC_DEC_EN_BIT 1
`define DPSC_ROUTE_MASK 8'h3E
// decimation_mode_control fields
`define DPSC_SEL_EN_BIT 7
`define DPSC_RATIO_HI 6
`define DPSC_RATIO_LO 4
`define DPSC_REAL_BIT 3
`define DPSC_PHASE_BIT 0
`define DPSC_DECIM_MASK 8'hF9
// reset values
`define DPSC_ROUTE_RST 8'h00
`define DPSC_DECIM_RST 8'h00
// largest used ratio code (divide by 32)
`define DPSC_RATIO_MAX 3'h5
`endif

// *** logic/dpsc_pkg.sv ***
package dpsc_pkg;
   // input select codes
   typedef enum logic [1:0] {
      DPSC_SEL_STRAIGHT = 2'h0,
      DPSC_SEL_A_BOTH = 2'h1,
      DPSC_SEL_B_BOTH = 2'h2,
      DPSC_SEL_AVG = 2'h3
   } dpsc_sel_t;
   // one sample for each of the two paths
   typedef struct packed {
      logic [15:0] a;
      logic [15:0] b;
   } dpsc_pair_t;
   // decoded configuration handed to the data path
   typedef struct packed {
      logic avg_en;
      dpsc_sel_t sel;
      logic sel_en;
      logic feat;
      logic dec_en;
      logic [2:0] ratio;
      logic real_mode;
      logic phase_inv;
   } dpsc_cfg_t;
   // ratio code to shift count; unused codes act as no decimation
   function automatic logic [2:0] dpsc_ratio_shift(input logic [2:0] code);
      dpsc_ratio_shift = (code > 3'h5) ? 3'h0 : code;
   endfunction
endpackage

// *** logic/dpsc_route.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpsc_route
   import dpsc_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // samples in
   input wire dpsc_pkg::dpsc_pair_t raw_i,
   input wire logic valid_i,
   // routing controls
   input wire logic avg_en_i,
   input wire logic sel_en_i,
   input wire dpsc_pkg::dpsc_sel_t sel_i,
   // routed samples
   output dpsc_pkg::dpsc_pair_t pair_o,
   output logic valid_o
);
   logic signed [16:0] sum_w; // one extra bit so the sum cannot wrap
   logic [15:0] avg_w;
   dpsc_pair_t pair_d;

   // averaging block; without its enable it just passes channel A
   always_comb begin
      sum_w = $signed({raw_i.a[15], raw_i.a}) + $signed({raw_i.b[15], raw_i.b});
      avg_w = avg_en_i ? sum_w[16:1] : raw_i.a;
   end

   // input multiplexer; disabled it falls back to straight routing
   always_comb begin
      pair_d = raw_i;
      if (sel_en_i) begin
         case (sel_i)
            DPSC_SEL_STRAIGHT: pair_d = raw_i;
            DPSC_SEL_A_BOTH: pair_d = '{a: raw_i.a, b: raw_i.a};
            DPSC_SEL_B_BOTH: pair_d = '{a: raw_i.b, b: raw_i.b};
            DPSC_SEL_AVG: pair_d = '{a: avg_w, b: avg_w};
            default: pair_d = raw_i;
         endcase
      end
   end

   // one register stage
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pair_o <= '0;
         valid_o <= 1'b0;
      end else begin
         pair_o <= pair_d;
         valid_o <= valid_i;
      end
   end
endmodule
`default_nettype wire

// *** logic/dpsc_decim.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpsc_decim #(
   parameter int W = 16
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // sample in
   input wire logic [W-1:0] sample_i,
   input wire logic valid_i,
   // controls
   input wire logic en_i,
   input wire logic [2:0] shift_i,
   input wire logic real_i,
   input wire logic mix_neg_i,
   // sample out
   output logic [W-1:0] sample_o,
   output logic valid_o
);
   logic signed [W+5:0] acc_q; // room for 32 samples
   logic [4:0] cnt_q;
   logic [4:0] last_w;
   logic signed [W+5:0] in_w;
   logic signed [W+5:0] tot_w;

   // complex mode mixes by the oscillator sign; real mode skips it
   always_comb begin
      in_w = (W+6)'($signed(sample_i));
      if (!real_i && mix_neg_i) begin
         in_w = -in_w;
      end
      last_w = 5'((32'd1 << shift_i) - 32'd1);
      tot_w = acc_q + in_w;
   end

   // boxcar low pass: sum a block of samples, then scale down
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acc_q <= '0;
         cnt_q <= '0;
         sample_o <= '0;
         valid_o <= 1'b0;
      end else begin
         valid_o <= 1'b0;
         if (!en_i) begin
            acc_q <= '0;
            cnt_q <= '0;
         end else if (valid_i) begin
            if (cnt_q == last_w) begin
               sample_o <= W'(tot_w >>> shift_i);
               valid_o <= 1'b1;
               acc_q <= '0;
               cnt_q <= '0;
            end else begin
               acc_q <= tot_w;
               cnt_q <= cnt_q + 5'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** logic/dpsc_top.sv ***
// Functional notes
// - average enable gives (A+B)/2 of both channels
// - select codes route channels to the paths
// - code 11 feeds average into both paths
// - routing applies only while select is enabled
// - feature path off takes lowest latency route
// - decimator enable acts on both channels
// - ratio code picks divide by 1 to 32
// - one ratio governs both channels
// - real mode is low pass, else complex
// - phase invert negates oscillator phase
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_params.svh"
module dpsc_top #(
   parameter int PW = 16 // oscillator phase width
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // converter samples
   input wire dpsc_pkg::dpsc_pair_t adc_i,
   input wire logic adc_valid_i,
   // oscillator phase
   input wire logic [PW-1:0] nco_phase_i,
   output logic [PW-1:0] nco_phase_o,
   // downconverter path outputs
   output dpsc_pkg::dpsc_pair_t path_o,
   output logic path_valid_o,
   // configuration seen by neighbouring blocks
   output logic feature_path_o,
   output logic decim_en_o,
   output logic real_mode_o
);
   import dpsc_pkg::*;

   // latency: bypass and undecimated feature samples leave two edges after
   // they enter; decimated ones need the whole block, then one edge in the router, one in the
   // filter and one in the output flop
   // apb answers with zero wait states, and the master may begin the next
   // setup right after an access
   // the sample clock and the register clock are one and the same here

   // software registers, stored at full eight bits
   logic [7:0] route_q; // path_routing_control
   logic [7:0] decim_q; // decimation_mode_control

   // apb response flops
   logic [31:0] rdata_q;
   logic ready_q;
   logic err_q;

   // decoded configuration
   // rebuilt every cycle from the two registers, so it never goes stale
   dpsc_cfg_t cfg_w;

   // data path wires
   dpsc_pair_t routed_w;
   logic routed_valid_w;
   dpsc_pair_t dec_w; // both decimated samples, joined
   logic [15:0] dec_a_w; // path a filter output
   logic [15:0] dec_b_w; // path b filter output
   logic dec_a_valid_w;
   logic dec_b_valid_w;
   logic [2:0] shift_w;
   logic [PW-1:0] phase_w;
   logic mix_neg_w;

   // bypass delay stage, matches the routed stage by one cycle
   dpsc_pair_t bypass_q;
   logic bypass_valid_q;

   // output flops
   dpsc_pair_t path_q;
   logic path_valid_q;
   logic [PW-1:0] phase_q;
   logic feat_q;
   logic dec_en_q;
   logic real_q;

   // status: output sample counter, wraps
   logic [7:0] out_cnt_q;

   // word index of the current apb address
   logic [9:0] idx_w;
   logic aligned_w;
   logic hit_route_w;
   logic hit_decim_w;
   logic hit_stat_w;
   logic setup_w;
   logic write_w;

   // -------- apb decode --------

   // registers sit on word indices, so the byte address is four times one
   // bits 1:0 must be zero; byte lanes are not supported
   always_comb begin
      idx_w = paddr_i[11:2];
      aligned_w = (paddr_i[1:0] == 2'h0);
      hit_route_w = aligned_w && (idx_w == `DPSC_IDX_ROUTE);
      hit_decim_w = aligned_w && (idx_w == `DPSC_IDX_DECIM);
      hit_stat_w = aligned_w && (idx_w == `DPSC_IDX_STAT);
      setup_w = psel_i && !penable_i;
      // a write lands only at the edge that completes the access
      write_w = psel_i && penable_i && ready_q && pwrite_i;
   end

   // answer is prepared during setup, so access phase never waits
   // trade-off: one fixed access cycle keeps the bus simple, but a future
   // register with slow side effects must still fit inside it
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= setup_w;
      end
   end

   // unmapped addresses complete with an error and change nothing
   // the status word is read only: a write to it completes without error
   // and is dropped
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         err_q <= 1'b0;
      end else if (setup_w) begin
         err_q <= !(hit_route_w || hit_decim_w || hit_stat_w);
      end else begin
         err_q <= 1'b0;
      end
   end

   // read data captured in setup; config cannot change before access ends
   // clearing it while idle keeps stale values off the bus, so a reader
   // that looks outside a transfer sees zero once the first idle edge has passed
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q <= '0;
      end else if (setup_w && !pwrite_i) begin
         if (hit_route_w) begin
            rdata_q <= {24'h000000, route_q};
         end else if (hit_decim_w) begin
            rdata_q <= {24'h000000, decim_q};
         end else if (hit_stat_w) begin
            rdata_q <= {24'h000000, out_cnt_q};
         end else begin
            rdata_q <= '0;
         end
      end else if (!psel_i) begin
         rdata_q <= '0;
      end
   end

   // -------- software registers --------

   // both registers reset to zero: bypass path, filter off, select off
   // reserved bits are masked off, so they read zero and steer nothing
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         route_q <= `DPSC_ROUTE_RST;
      end else if (write_w && hit_route_w) begin
         route_q <= pwdata_i[7:0] & `DPSC_ROUTE_MASK;
      end
   end

   // second control register, same masking
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         decim_q <= `DPSC_DECIM_RST;
      end else if (write_w && hit_decim_w) begin
         decim_q <= pwdata_i[7:0] & `DPSC_DECIM_MASK;
      end
   end

   // field extraction; averaging set-up is left to software
   // no combination is refused: fields that do not form an averaging setup
   // still route, just not as averages
   always_comb begin
      cfg_w.avg_en = route_q[`DPSC_AVG_BIT];
      cfg_w.sel = dpsc_sel_t'(route_q[`DPSC_SEL_HI:`DPSC_SEL_LO]);
      cfg_w.feat = route_q[`DPSC_FEAT_BIT];
      cfg_w.dec_en = route_q[`DPSC_DEC_EN_BIT];
      cfg_w.sel_en = decim_q[`DPSC_SEL_EN_BIT];
      cfg_w.ratio = decim_q[`DPSC_RATIO_HI:`DPSC_RATIO_LO];
      cfg_w.real_mode = decim_q[`DPSC_REAL_BIT];
      cfg_w.phase_inv = decim_q[`DPSC_PHASE_BIT];
   end

   // -------- oscillator phase --------

   // inversion is a two's complement negate of the phase word
   // a zero phase stays zero when inverted
   // limitation: mixing is only a sign flip by the phase msb, a stand-in
   // for the real oscillator that lives outside this block
   always_comb begin
      phase_w = cfg_w.phase_inv ? PW'(-nco_phase_i) : nco_phase_i;
      // sign of the phase picks the mixing sign for complex mode
      mix_neg_w = phase_w[PW-1];
      // one shift count serves both channels
      shift_w = dpsc_ratio_shift(cfg_w.ratio);
   end

   // -------- data path --------

   // input selection and averaging
   // the router adds one register stage in front of the filters
   dpsc_route u_route (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .raw_i(adc_i),
      .valid_i(adc_valid_i),
      .avg_en_i(cfg_w.avg_en),
      .sel_en_i(cfg_w.sel_en),
      .sel_i(cfg_w.sel),
      .pair_o(routed_w),
      .valid_o(routed_valid_w)
   );

   // path a decimator
   // the filter restarts its count whenever the enable is low
   dpsc_decim #(
      .W(16)
   ) u_dec_a (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .sample_i(routed_w.a),
      .valid_i(routed_valid_w),
      .en_i(cfg_w.dec_en),
      .shift_i(shift_w),
      .real_i(cfg_w.real_mode),
      .mix_neg_i(mix_neg_w),
      .sample_o(dec_a_w),
      .valid_o(dec_a_valid_w)
   );

   // path b decimator, same ratio and mode as path a
   // sharing shift and mode inputs is what keeps the two paths identical
   dpsc_decim #(
      .W(16)
   ) u_dec_b (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .sample_i(routed_w.b),
      .valid_i(routed_valid_w),
      .en_i(cfg_w.dec_en),
      .shift_i(shift_w),
      .real_i(cfg_w.real_mode),
      .mix_neg_i(mix_neg_w),
      .sample_o(dec_b_w),
      .valid_o(dec_b_valid_w)
   );

   // the two filter outputs come from separate instances, so each has its
   // own net and they are joined here into one carrier
   always_comb begin
      dec_w.a = dec_a_w;
      dec_w.b = dec_b_w;
   end

   // bypass register; raw channels never see the mux or filter
   // it also keeps bypass latency equal to the undecimated feature path
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bypass_q <= '0;
         bypass_valid_q <= 1'b0;
      end else begin
         bypass_q <= adc_i;
         bypass_valid_q <= adc_valid_i;
      end
   end

   // output selection: bypass, full rate features, or decimated
   // switching paths mid stream may drop or repeat one sample; software
   // should change these fields only while the converter is idle
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         path_q <= '0;
         path_valid_q <= 1'b0;
      end else if (!cfg_w.feat) begin
         // lowest latency: skip the whole feature block
         path_q <= bypass_q;
         path_valid_q <= bypass_valid_q;
      end else if (!cfg_w.dec_en) begin
         // feature path with filter off passes routed samples
         path_q <= routed_w;
         path_valid_q <= routed_valid_w;
      end else begin
         // both filters run in lock step; the a and b strobes are anded into one
         path_q <= dec_w;
         path_valid_q <= dec_a_valid_w && dec_b_valid_w;
      end
   end

   // configuration and phase outputs, registered
   // neighbours see a register write one edge after it lands
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         phase_q <= '0;
         feat_q <= 1'b0;
         dec_en_q <= 1'b0;
         real_q <= 1'b0;
      end else begin
         phase_q <= phase_w;
         feat_q <= cfg_w.feat;
         dec_en_q <= cfg_w.dec_en;
         real_q <= cfg_w.real_mode;
      end
   end

   // status counter of delivered output samples
   // eight bits wrap silently, so software must poll often enough
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_cnt_q <= '0;
      end else if (path_valid_q) begin
         out_cnt_q <= out_cnt_q + 8'h01;
      end
   end

   // -------- outputs --------
   // every output is a flop output; these assigns only rename
   assign prdata_o = rdata_q;
   assign pready_o = ready_q;
   assign pslverr_o = err_q;
   assign path_o = path_q;
   assign path_valid_o = path_valid_q;
   assign nco_phase_o = phase_q;
   assign feature_path_o = feat_q;
   assign decim_en_o = dec_en_q;
   assign real_mode_o = real_q;
endmodule
`default_nettype wire

// *** dv/dpsc_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpsc_asserts #(
   parameter int PW = 16
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // apb slave side
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // data path
   input wire logic adc_valid_i,
   input wire logic [PW-1:0] nco_phase_i,
   input wire logic [PW-1:0] nco_phase_o,
   input wire logic path_valid_o,
   input wire logic feature_path_o,
   input wire logic decim_en_o,
   input wire logic real_mode_o
);
   // raw shadows keep reserved bits so a missing mask shows up on read
   logic [7:0] route_q;
   logic [7:0] decim_q;
   logic wr_ok;
   assign wr_ok = psel_i && penable_i && pready_o && pwrite_i;
   // shadow of the routing word
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         route_q <= 8'h00;
      end else if (wr_ok && paddr_i == 12'h090) begin
         route_q <= pwdata_i[7:0];
      end
   end
   // shadow of the decimation word
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         decim_q <= 8'h00;
      end else if (wr_ok && paddr_i == 12'h094) begin
         decim_q <= pwdata_i[7:0];
      end
   end
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);
   // setup cycle followed by the first access cycle
   sequence setup_s;
      psel_i && !penable_i ##1 psel_i && penable_i;
   endsequence
   // a sample enters while the decimator stays off
   sequence plain_in_s;
      adc_valid_i && !route_q[1] ##1 !route_q[1];
   endsequence
   ready_first_a: assert property (setup_s |-> pready_o)
      else $error("no ready in first access cycle");
   err_map_a: assert property (pready_o && !(paddr_i inside {12'h090, 12'h094, 12'h0A0})
      |-> pslverr_o) else $error("unmapped access without error");
   route_rd_a: assert property (pready_o && !pwrite_i && paddr_i == 12'h090 |->
      prdata_o == {24'h000000, route_q & 8'h3E}) else $error("routing word misread");
   decim_rd_a: assert property (pready_o && !pwrite_i && paddr_i == 12'h094 |->
      prdata_o == {24'h000000, decim_q & 8'hF9}) else $error("decimation word misread");
   plain_lat_a: assert property (plain_in_s |=> path_valid_o)
      else $error("undecimated sample late");
   feat_follow_a: assert property ($stable(route_q[2]) |-> feature_path_o == route_q[2])
      else $error("feature path flag wrong");
   dec_follow_a: assert property ($stable(route_q[1]) |-> decim_en_o == route_q[1])
      else $error("decimator flag wrong");
   real_follow_a: assert property ($stable(decim_q[3]) |-> real_mode_o == decim_q[3])
      else $error("real mode flag wrong");
   phase_inv_a: assert property ($past(rst_b_i, 2) && $past(rst_b_i) |-> nco_phase_o ==
      ($past(decim_q[0]) ? PW'(-$past(nco_phase_i)) : $past(nco_phase_i)))
      else $error("oscillator phase wrong");
endmodule
bind dpsc_top dpsc_asserts #(.PW(PW)) u_chk (.mclk_i, .rst_b_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .adc_valid_i,
   .nco_phase_i, .nco_phase_o, .path_valid_o, .feature_path_o, .decim_en_o, .real_mode_o);
`default_nettype wire

// *** dv/test_ddc_path_select_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_ddc_path_select_control;
   import dpsc_pkg::*;
   // design inputs and outputs
   logic mclk_i = 1'b0;
   logic rst_b_i, psel_i, penable_i, pwrite_i, adc_valid_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o;
   logic pready_o, pslverr_o, path_valid_o, feature_path_o, decim_en_o, real_mode_o;
   dpsc_pair_t adc_i, path_o;
   logic [15:0] nco_phase_i, nco_phase_o;
   int num_errors = 0;
   int n_checks = 0;
   localparam logic [11:0] RT = 12'h090;
   localparam logic [11:0] DC = 12'h094;
   dpsc_top #(.PW(16)) dut (.mclk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .adc_i, .adc_valid_i, .nco_phase_i,
      .nco_phase_o, .path_o, .path_valid_o, .feature_path_o, .decim_en_o, .real_mode_o);
   // 50 MHz clock
   always #10 mclk_i = ~mclk_i;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer; ready, read data and error are taken at the rising
   // edge that completes the access, before that edge's updates land
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v,
         output logic [31:0] d, output logic er);
      int n;
      n = 0;
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= {24'h000000, v};
      @(posedge mclk_i);
      penable_i <= 1'b1;
      @(posedge mclk_i);
      while (pready_o !== 1'b1 && n < 20) begin
         n++;
         @(posedge mclk_i);
      end
      chk("pready", {31'h0, pready_o}, 32'h1);
      d = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      logic [31:0] d;
      logic er;
      apb(1'b1, a, v, d, er);
   endtask
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e,
         input logic ee);
      logic [31:0] d;
      logic er;
      apb(1'b0, a, 8'h00, d, er);
      chk(nm, d, e);
      chk("pslverr", {31'h0, er}, {31'h0, ee});
   endtask
   // n samples on consecutive cycles, both channels stepping together
   task automatic feed(input int n, input logic [15:0] a, input logic [15:0] b,
         input logic [15:0] st);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk_i);
         adc_valid_i <= 1'b1;
         adc_i <= '{a: a + 16'(i) * st, b: b + 16'(i) * st};
      end
      @(posedge mclk_i);
      adc_valid_i <= 1'b0;
   endtask
   // bounded wait for one path sample
   task automatic grab(output dpsc_pair_t p);
      int n;
      n = 0;
      @(negedge mclk_i);
      while (path_valid_o !== 1'b1 && n < 60) begin
         n++;
         @(negedge mclk_i);
      end
      chk("path_valid", {31'h0, path_valid_o}, 32'h1);
      p = path_o;
   endtask
   task automatic t_regs();
      rd("route reset", RT, 32'h0, 1'b0);
      rd("decim reset", DC, 32'h0, 1'b0);
      wr(RT, 8'hFF);
      wr(DC, 8'hFF);
      wr(12'h0A4, 8'hFF);
      rd("route", RT, 32'h3E, 1'b0);
      rd("decim", DC, 32'hF9, 1'b0);
      rd("hole", 12'h0A4, 32'h0, 1'b1);
      chk("feature", {31'h0, feature_path_o}, 32'h1);
      chk("dec_en", {31'h0, decim_en_o}, 32'h1);
      chk("real", {31'h0, real_mode_o}, 32'h1);
      $display("test regs done");
   endtask
   // every select code, with the input select off and on
   task automatic t_route();
      dpsc_pair_t e;
      dpsc_pair_t p;
      logic [1:0] s;
      logic en;
      for (int m = 0; m < 8; m++) begin
         s = 2'(m);
         en = m[2];
         wr(DC, {en, 7'h08});
         wr(RT, {3'b001, s, 1'b1, en, 1'b0});
         e = '{a: 16'h7FFF, b: 16'h7FFD};
         if (en && s == 2'h1) e.b = 16'h7FFF;
         if (en && s == 2'h2) e.a = 16'h7FFD;
         if (en && s == 2'h3) e = '{a: 16'h7FFE, b: 16'h7FFE};
         feed(1, 16'h7FFF, 16'h7FFD, 16'h0000);
         grab(p);
         chk("route", p, e);
      end
      // each of the eight samples gave exactly one path strobe
      rd("status", 12'h0A0, 32'h8, 1'b0);
      $display("test route done");
   endtask
   // all used ratio codes; disabling first restarts the filter count
   task automatic t_decim();
      dpsc_pair_t p;
      int n;
      for (int k = 0; k < 6; k++) begin
         n = 1 << k;
         wr(RT, 8'h04);
         wr(DC, {1'b1, 3'(k), 4'h8});
         wr(RT, 8'h06);
         feed(n, 16'h0000, 16'h0100, 16'h0002);
         grab(p);
         chk("decim", p, {16'(n - 1), 16'(n + 255)});
      end
      $display("test decim done");
   endtask
   // phase inversion flips the mixer sign in complex mode only
   task automatic t_mix();
      dpsc_pair_t p;
      logic rl;
      logic iv;
      @(posedge mclk_i);
      nco_phase_i <= 16'h4000;
      wr(RT, 8'h06);
      for (int m = 0; m < 4; m++) begin
         rl = (m >= 2);
         iv = (m != 0);
         if (m == 3) begin
            @(posedge mclk_i);
            nco_phase_i <= 16'h0000;
         end
         wr(DC, {4'h8, rl, 2'b00, iv});
         feed(1, 16'h0123, 16'hFEDC, 16'h0000);
         grab(p);
         chk("mix", p, (iv && !rl) ? 32'hFEDD0124 : 32'h0123FEDC);
         chk("phase", {16'h0, nco_phase_o}, (m > 2) ? 32'h0 : iv ? 32'hC000 : 32'h4000);
      end
      $display("test mix done");
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      rst_b_i = 1'b0;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = '0;
      pwdata_i = '0;
      adc_valid_i = 1'b0;
      adc_i = '0;
      nco_phase_i = '0;
      repeat (2) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      t_regs();
      t_route();
      t_decim();
      t_mix();
      wrap_up();
   end
   // the run needs well under 2000 cycles
   initial begin
      #200000;
      num_errors++;
      wrap_up();
   end
endmodule
`default_nettype wire
